// ### core/csll_core.sv
// Local design decision: the address-and-strobe port.
`default_nettype none
module csll_core
   import csll_pkg::*;
#(
   parameter int CYC_PER_MS = NS_PER_MS / CLK_NS,
   parameter int EDGE_W = 16,
   parameter int EDGE_LSB_PS = 625
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire csll_bus_t bus,
   output logic [7:0] rdata,
   input wire logic supply_on_a,
   input wire logic supply_on_b,
   input wire logic [11:0] current_reading_a,
   input wire logic [11:0] current_reading_b,
   input wire logic current_upd_a,
   input wire logic current_upd_b,
   input wire logic [11:0] ref_target_a,
   input wire logic [11:0] ref_target_b,
   input wire csll_fault_t fault_a,
   input wire csll_fault_t fault_b,
   input wire logic sw_cycle,
   input wire logic [EDGE_W-1:0] rise_1,
   input wire logic [EDGE_W-1:0] fall_1,
   input wire logic [EDGE_W-1:0] rise_2,
   input wire logic [EDGE_W-1:0] fall_2,
   input wire logic [1:0] fall_pos_mod,
   output logic low_load_flag_a,
   output logic low_load_flag_b,
   output logic [7:0] pwm_shed_a,
   output logic [7:0] pwm_shed_b,
   output logic light_coeff_a,
   output logic light_coeff_b,
   output logic [2:0] channel_on,
   output logic [11:0] ref_a,
   output logic [11:0] ref_b,
   output logic [EDGE_W-1:0] odd_output_variation,
   output logic [EDGE_W-1:0] even_output_variation,
   output logic [EDGE_W-1:0] fall_1_adj,
   output logic [EDGE_W-1:0] fall_2_adj,
   input wire logic power_ok_a_in,
   output logic power_ok_a_out,
   output logic power_ok_a_oe,
   input wire logic power_ok_b_in,
   output logic power_ok_b_out,
   output logic power_ok_b_oe,
   output logic flag_sync_out_pin_out,
   output logic flag_sync_out_pin_oe
);
   localparam int MS_W = $clog2(CYC_PER_MS + 1);
   localparam int RAMP_CYC [4] = '{
      RAMP_NS_PER_V[0] / (REF_LSB_PER_V * CLK_NS),
      RAMP_NS_PER_V[1] / (REF_LSB_PER_V * CLK_NS),
      RAMP_NS_PER_V[2] / (REF_LSB_PER_V * CLK_NS),
      RAMP_NS_PER_V[3] / (REF_LSB_PER_V * CLK_NS)};
   localparam int SS_STEP = (SS_STEP_NS * 1000) / EDGE_LSB_PS;

   if (CYC_PER_MS < 2 || EDGE_W < 8 || SS_STEP < 1) begin : g_bad_param
      $error("csll_core: unsupported parameter value");
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [7:0] dbc_cfg, pginc_cfg, flag_cfg, ssc_cfg, rst_cfg;
   logic [7:0] thr_cfg [2];
   logic [7:0] ramp_cfg [2];
   logic [7:0] shed_cfg [2];
   logic [7:0] seq_cfg [3];
   logic [1:0] rst_cmd;
   logic [MS_W-1:0] ms_cnt;
   logic ms_tick;
   logic [1:0] pin_meta, pin_sync, pok_meta, pok_sync;
   logic [2:0] en, restart, ramp_done;
   csll_seq_t st [3];
   logic [11:0] cur [2];
   logic [1:0] cur_upd, ll, pg_fault, raw_fault;
   logic [11:0] tgt [2];
   logic [11:0] refv [2];
   csll_fault_t flt [2];
   logic [7:0] stat [2];
   logic [EDGE_W-1:0] off_odd, off_even;
   logic [2:0] ss_cnt;

   assign cur[0] = current_reading_a;
   assign cur[1] = current_reading_b;
   assign cur_upd = {current_upd_b, current_upd_a};
   assign tgt[0] = ref_target_a;
   assign tgt[1] = ref_target_b;
   assign flt[0] = fault_a;
   assign flt[1] = fault_b;

   // register writes; restart bits are one-cycle commands
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dbc_cfg <= REG_RESET;
         pginc_cfg <= REG_RESET;
         flag_cfg <= REG_RESET;
         ssc_cfg <= REG_RESET;
         rst_cfg <= REG_RESET;
         thr_cfg <= '{REG_RESET, REG_RESET};
         ramp_cfg <= '{REG_RESET, REG_RESET};
         shed_cfg <= '{REG_RESET, REG_RESET};
         seq_cfg <= '{REG_RESET, REG_RESET, REG_RESET};
         rst_cmd <= 2'h0;
      end else begin
         rst_cmd <= 2'h0;
         if (bus.wr) begin
            case (bus.addr)
               ADDR_DBC: dbc_cfg <= bus.wdata;
               ADDR_PGINC: pginc_cfg <= bus.wdata;
               ADDR_FLAG: flag_cfg <= bus.wdata;
               ADDR_THR_A: thr_cfg[0] <= bus.wdata;
               ADDR_THR_B: thr_cfg[1] <= bus.wdata;
               ADDR_RAMP_A: ramp_cfg[0] <= bus.wdata;
               ADDR_RAMP_B: ramp_cfg[1] <= bus.wdata;
               ADDR_SSC: ssc_cfg <= bus.wdata;
               ADDR_SHED_A: shed_cfg[0] <= bus.wdata;
               ADDR_SHED_B: shed_cfg[1] <= bus.wdata;
               ADDR_SEQ_A: seq_cfg[0] <= bus.wdata;
               ADDR_SEQ_B: seq_cfg[1] <= bus.wdata;
               ADDR_SEQ_C: seq_cfg[2] <= bus.wdata;
               ADDR_RST: begin
                  rst_cfg <= {4'h0, bus.wdata[3:2], 2'h0};
                  rst_cmd <= bus.wdata[1:0];
               end
               default: ;
            endcase
         end
      end
   end

   // read data stands in the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= 8'h00;
         if (bus.rd) begin
            case (bus.addr)
               ADDR_DBC: rdata <= dbc_cfg;
               ADDR_PGINC: rdata <= pginc_cfg;
               ADDR_FLAG: rdata <= flag_cfg;
               ADDR_THR_A: rdata <= thr_cfg[0];
               ADDR_THR_B: rdata <= thr_cfg[1];
               ADDR_RAMP_A: rdata <= ramp_cfg[0];
               ADDR_RAMP_B: rdata <= ramp_cfg[1];
               ADDR_SSC: rdata <= ssc_cfg;
               ADDR_SHED_A: rdata <= shed_cfg[0];
               ADDR_SHED_B: rdata <= shed_cfg[1];
               ADDR_SEQ_A: rdata <= seq_cfg[0];
               ADDR_SEQ_B: rdata <= seq_cfg[1];
               ADDR_SEQ_C: rdata <= seq_cfg[2];
               ADDR_RST: rdata <= rst_cfg;
               ADDR_STAT_A: rdata <= stat[0];
               ADDR_STAT_B: rdata <= stat[1];
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   // millisecond tick paces every delay and debounce
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ms_cnt <= '0;
      end else if (ms_tick) begin
         ms_cnt <= '0;
      end else begin
         ms_cnt <= ms_cnt + 1'b1;
      end
   end
   assign ms_tick = (ms_cnt == MS_W'(CYC_PER_MS - 1));

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
         pok_meta <= 2'h0;
         pok_sync <= 2'h0;
      end else begin
         pin_meta <= {supply_on_b, supply_on_a};
         pin_sync <= pin_meta;
         pok_meta <= {power_ok_b_in, power_ok_a_in};
         pok_sync <= pok_meta;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_reg
      logic [12:0] enter_lvl, exit_lvl;
      logic [1:0] src;
      logic sw_en;
      logic [DLY_W-1:0] dcnt;
      logic [DLY_W-1:0] dbc_time;
      logic [11:0] rcnt;

      assign enter_lvl = {3'h0, thr_cfg[i][3:0], 6'h00};
      assign exit_lvl = enter_lvl + LL_HYST;
      assign src = seq_cfg[i][SEQ_SRC_LSB +: 2];
      assign sw_en = seq_cfg[i][SEQ_SW_EN_BIT];

      always_comb begin
         case (src)
            SRC_PIN: en[i] = pin_sync[i];
            SRC_SW: en[i] = sw_en;
            SRC_AND: en[i] = pin_sync[i] & sw_en;
            default: en[i] = pin_sync[i] | sw_en;
         endcase
      end
      assign restart[i] = rst_cmd[i];

      // low-load mode, evaluated on each reading update
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            ll[i] <= 1'b0;
         end else if (thr_cfg[i][3:0] == 4'h0) begin
            ll[i] <= 1'b0;
         end else if (cur_upd[i]) begin
            if (!ll[i] && {1'b0, cur[i]} < enter_lvl) begin
               ll[i] <= 1'b1;
            end else if (ll[i] && {1'b0, cur[i]} > exit_lvl) begin
               ll[i] <= 1'b0;
            end
         end
      end

      // overvoltage/overcurrent only reach here through psu
      assign raw_fault[i] = flt[i].crc | flt[i].psu | flt[i].uv |
         flt[i].ramp_filter |
         (pginc_cfg[2*i+PGINC_SENSE_BIT] & flt[i].input_sense) |
         (pginc_cfg[2*i+PGINC_OTW_BIT] & flt[i].otw);

      // set and release times from separate fields
      assign dbc_time = raw_fault[i] ?
         DLY_W'(DBC_MS[dbc_cfg[4*i +: DBC_FIELD_W]]) :
         DLY_W'(DBC_MS[dbc_cfg[4*i+DBC_FIELD_W +: DBC_FIELD_W]]);

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            pg_fault[i] <= 1'b1;
            dcnt <= '0;
         end else if (raw_fault[i] == pg_fault[i]) begin
            dcnt <= '0;
         end else if (dcnt >= dbc_time) begin
            pg_fault[i] <= raw_fault[i];
            dcnt <= '0;
         end else if (ms_tick) begin
            dcnt <= dcnt + 1'b1;
         end
      end

      // reference ramp from zero to target
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            refv[i] <= 12'h000;
            rcnt <= 12'h000;
         end else if (st[i] == SQ_RAMP) begin
            if (rcnt >= 12'(RAMP_CYC[ramp_cfg[i][1:0]] - 1)) begin
               rcnt <= 12'h000;
               if (refv[i] < tgt[i]) begin
                  refv[i] <= refv[i] + 1'b1;
               end
            end else begin
               rcnt <= rcnt + 1'b1;
            end
         end else if (st[i] == SQ_ON || st[i] == SQ_OFF_WAIT) begin
            refv[i] <= tgt[i];
            rcnt <= 12'h000;
         end else begin
            refv[i] <= 12'h000;
            rcnt <= 12'h000;
         end
      end
      assign ramp_done[i] = (refv[i] >= tgt[i]);

      always_comb begin
         stat[i] = 8'h00;
         stat[i][STAT_ON_BIT] = channel_on[i];
         stat[i][STAT_LL_BIT] = ll[i];
         stat[i][STAT_RAMP_BIT] = (st[i] == SQ_RAMP);
         stat[i][STAT_PG_BIT] = pg_fault[i];
         stat[i][STAT_PIN_BIT] = pok_sync[i];
      end

      chk_thr_zero_clear: assert property (
         thr_cfg[i][3:0] == 4'h0 |=> !ll[i])
         else $error("low-load flag set with zero threshold");
      chk_ll_enter: assert property (
         cur_upd[i] && thr_cfg[i][3:0] != 4'h0 && !ll[i] &&
         {1'b0, cur[i]} < enter_lvl && $stable(thr_cfg[i]) |=> ll[i])
         else $error("low-load mode not entered below threshold");
      chk_ll_hyst_hold: assert property (
         ll[i] && thr_cfg[i][3:0] != 4'h0 && !cur_upd[i] |=> ll[i])
         else $error("low-load mode left without a reading update");
      chk_shed_apply: assert property (
         $rose(ll[i]) |=> (i == 0 ? pwm_shed_a : pwm_shed_b) ==
         $past(shed_cfg[i]) && (i == 0 ? light_coeff_a : light_coeff_b))
         else $error("shed outputs or coefficients missing on entry");
      chk_restart_off: assert property (
         restart[i] && (st[i] == SQ_ON || st[i] == SQ_RAMP) && en[i] |=>
         st[i] == SQ_RESTART && !channel_on[i])
         else $error("restart did not turn the channel off");
      chk_pg_release: assert property (
         pg_fault[i] && !raw_fault[i] &&
         dbc_cfg[4*i+DBC_FIELD_W +: DBC_FIELD_W] == 2'h0 &&
         $stable(dbc_cfg) ##1 !raw_fault[i] |-> !pg_fault[i])
         else $error("fault release not immediate at zero debounce");
   end

   assign restart[2] = 1'b0;
   assign en[2] = seq_cfg[2][SEQC_FOLLOW_BIT] ? (en[0] | en[1])
                                               : 1'b1;

   // sequencing state per channel, delays counted in milliseconds
   for (genvar k = 0; k < 3; k++) begin : g_seq
      logic [DLY_W-1:0] cnt;
      logic [DLY_W-1:0] don, doff, drst;

      assign don = DLY_W'(SEQ_DLY_MS[seq_cfg[k][1:0]]);
      assign doff = DLY_W'(SEQ_DLY_MS[seq_cfg[k][SEQ_OFF_LSB +: 2]]);
      assign drst = DLY_W'(RST_DLY_MS[rst_cfg[RST_DLY_LSB +: 2]]);

      always_ff @(posedge clk) begin
         if (!rst_n) begin
            st[k] <= SQ_OFF;
            cnt <= '0;
         end else begin
            if (ms_tick && cnt != '0) begin
               cnt <= cnt - 1'b1;
            end
            case (st[k])
               SQ_OFF: begin
                  if (en[k]) begin
                     st[k] <= SQ_ON_WAIT;
                     cnt <= don;
                  end
               end
               SQ_ON_WAIT: begin
                  if (!en[k]) begin
                     st[k] <= SQ_OFF;
                  end else if (cnt == '0) begin
                     st[k] <= SQ_RAMP;
                  end
               end
               SQ_RAMP, SQ_ON: begin
                  if (restart[k]) begin
                     st[k] <= SQ_RESTART;
                     cnt <= drst;
                  end else if (!en[k]) begin
                     st[k] <= SQ_OFF_WAIT;
                     cnt <= doff;
                  end else if (ramp_done[k]) begin
                     st[k] <= SQ_ON;
                  end
               end
               SQ_OFF_WAIT: begin
                  if (restart[k]) begin
                     st[k] <= SQ_RESTART;
                     cnt <= drst;
                  end else if (en[k]) begin
                     st[k] <= SQ_ON;
                  end else if (cnt == '0) begin
                     st[k] <= SQ_OFF;
                  end
               end
               SQ_RESTART: begin
                  if (!en[k]) begin
                     st[k] <= SQ_OFF;
                  end else if (cnt == '0) begin
                     st[k] <= SQ_RAMP;
                  end
               end
               default: st[k] <= SQ_OFF;
            endcase
         end
      end
      assign channel_on[k] = (st[k] == SQ_RAMP) || (st[k] == SQ_ON) ||
                             (st[k] == SQ_OFF_WAIT);
   end

   // fixed-duty soft start: offsets shrink to zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         odd_output_variation <= '0;
         even_output_variation <= '0;
      end else begin
         odd_output_variation <= (fall_1 > rise_1) ? fall_1 - rise_1
                                 : rise_1 - fall_1;
         even_output_variation <= (fall_2 > rise_2) ? fall_2 - rise_2
                                  : rise_2 - fall_2;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         off_odd <= '0;
         off_even <= '0;
         ss_cnt <= 3'h0;
      end else if (st[2] != SQ_RAMP) begin
         off_odd <= (st[2] == SQ_OFF || st[2] == SQ_ON_WAIT) ?
                    odd_output_variation : '0;
         off_even <= (st[2] == SQ_OFF || st[2] == SQ_ON_WAIT) ?
                     even_output_variation : '0;
         ss_cnt <= 3'h0;
      end else if (sw_cycle) begin
         if (ss_cnt >= 3'((1 << ssc_cfg[SS_RATE_LSB +: 2]) - 1)) begin
            ss_cnt <= 3'h0;
            off_odd <= (off_odd > EDGE_W'(SS_STEP)) ?
                       off_odd - EDGE_W'(SS_STEP) : '0;
            off_even <= (off_even > EDGE_W'(SS_STEP)) ?
                        off_even - EDGE_W'(SS_STEP) : '0;
         end else begin
            ss_cnt <= ss_cnt + 1'b1;
         end
      end
   end
   assign ramp_done[2] = (off_odd == '0) && (off_even == '0);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fall_1_adj <= '0;
         fall_2_adj <= '0;
      end else begin
         fall_1_adj <= fall_pos_mod[0] ? fall_1 + off_odd
                       : fall_1 - off_odd;
         fall_2_adj <= fall_pos_mod[1] ? fall_2 + off_even
                       : fall_2 - off_even;
      end
   end

   // outputs from the per-channel arrays
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwm_shed_a <= 8'h00;
         pwm_shed_b <= 8'h00;
         light_coeff_a <= 1'b0;
         light_coeff_b <= 1'b0;
         flag_sync_out_pin_out <= 1'b0;
         flag_sync_out_pin_oe <= 1'b0;
      end else begin
         pwm_shed_a <= next_shed(ll[0], shed_cfg[0]);
         pwm_shed_b <= next_shed(ll[1], shed_cfg[1]);
         light_coeff_a <= ll[0];
         light_coeff_b <= ll[1];
         flag_sync_out_pin_out <= (flag_cfg[FLAG_SEL_BIT] ? ll[1] : ll[0])
                                  ^ flag_cfg[FLAG_INV_BIT];
         flag_sync_out_pin_oe <= flag_cfg[FLAG_EN_BIT];
      end
   end

   function automatic logic [7:0] next_shed(input logic f,
                                            input logic [7:0] m);
      next_shed = f ? m : 8'h00;
   endfunction

   assign low_load_flag_a = ll[0];
   assign low_load_flag_b = ll[1];
   assign ref_a = refv[0];
   assign ref_b = refv[1];
   assign power_ok_a_out = 1'b0;
   assign power_ok_b_out = 1'b0;
   assign power_ok_a_oe = !pg_fault[0];
   assign power_ok_b_oe = !pg_fault[1];

   chk_flag_pin: assert property (
      ##1 flag_sync_out_pin_out == ($past(flag_cfg[FLAG_SEL_BIT]) ?
      $past(ll[1]) : $past(ll[0])) ^ $past(flag_cfg[FLAG_INV_BIT]))
      else $error("flag pin level does not match selection");
   chk_pg_pin_low: assert property (
      power_ok_a_oe |-> !pg_fault[0] && power_ok_a_out == 1'b0)
      else $error("power-ok pin driven while fault present");
   chk_c_always_on: assert property (
      !seq_cfg[2][SEQC_FOLLOW_BIT] && st[2] == SQ_OFF &&
      $stable(seq_cfg[2]) |=> st[2] == SQ_ON_WAIT)
      else $error("fixed-duty channel did not start when always on");
endmodule
`default_nettype wire

// ### core/csll_pkg.sv
`default_nettype none
package csll_pkg;
   // register byte addresses
   localparam logic [15:0] ADDR_DBC = 16'hfe09;
   localparam logic [15:0] ADDR_PGINC = 16'hfe0e;
   localparam logic [15:0] ADDR_FLAG = 16'hfe0f;
   localparam logic [15:0] ADDR_THR_A = 16'hfe1a;
   localparam logic [15:0] ADDR_THR_B = 16'hfe1b;
   localparam logic [15:0] ADDR_RAMP_A = 16'hfe2a;
   localparam logic [15:0] ADDR_RAMP_B = 16'hfe2b;
   localparam logic [15:0] ADDR_SSC = 16'hfe68;
   localparam logic [15:0] ADDR_SHED_A = 16'hfe69;
   localparam logic [15:0] ADDR_SHED_B = 16'hfe6a;
   localparam logic [15:0] ADDR_SEQ_A = 16'hfe79;
   localparam logic [15:0] ADDR_SEQ_B = 16'hfe7a;
   localparam logic [15:0] ADDR_SEQ_C = 16'hfe7b;
   localparam logic [15:0] ADDR_RST = 16'hfe88;
   localparam logic [15:0] ADDR_STAT_A = 16'hfec0;
   localparam logic [15:0] ADDR_STAT_B = 16'hfec1;
   // field positions
   localparam int FLAG_EN_BIT = 3;
   localparam int FLAG_SEL_BIT = 4;
   localparam int FLAG_INV_BIT = 5;
   localparam int STAT_ON_BIT = 0;
   localparam int STAT_LL_BIT = 1;
   localparam int STAT_RAMP_BIT = 2;
   localparam int STAT_PG_BIT = 6;
   localparam int STAT_PIN_BIT = 7;
   localparam int SEQ_OFF_LSB = 2;
   localparam int SEQ_SRC_LSB = 4;
   localparam int SEQ_SW_EN_BIT = 6;
   localparam int SEQC_FOLLOW_BIT = 4;
   localparam int RST_DLY_LSB = 2;
   localparam int SS_RATE_LSB = 4;
   localparam int DBC_FIELD_W = 2;
   localparam int PGINC_SENSE_BIT = 0;
   localparam int PGINC_OTW_BIT = 1;
   localparam logic [7:0] REG_RESET = 8'h00;
   // light-load comparison
   localparam int THR_STEP_SHIFT = 6;
   localparam logic [12:0] LL_HYST = 13'h060;
   // enable source selection
   localparam logic [1:0] SRC_PIN = 2'h0;
   localparam logic [1:0] SRC_SW = 2'h1;
   localparam logic [1:0] SRC_AND = 2'h2;
   // timing
   localparam int CLK_NS = 8;
   localparam int NS_PER_MS = 1000000;
   localparam int SEQ_DLY_MS [4] = '{0, 50, 250, 1000};
   localparam int DBC_MS [4] = '{0, 200, 320, 600};
   localparam int RST_DLY_MS [4] = '{0, 500, 1000, 2000};
   localparam int RAMP_NS_PER_V [4] = '{1750000, 10500000, 21000000,
                                        40200000};
   localparam int REF_LSB_PER_V = 2560;
   localparam int SS_STEP_NS = 40;
   localparam int DLY_W = 11;

   typedef enum logic [2:0] {
      SQ_OFF,
      SQ_ON_WAIT,
      SQ_RAMP,
      SQ_ON,
      SQ_OFF_WAIT,
      SQ_RESTART
   } csll_seq_t;

   typedef struct packed {
      logic crc;
      logic psu;
      logic uv;
      logic ramp_filter;
      logic input_sense;
      logic otw;
   } csll_fault_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } csll_bus_t;
endpackage
`default_nettype wire

// ### test/csll_partner.sv
`default_nettype none
module csll_partner (
   input wire logic en_a,
   input wire logic en_b,
   input wire logic ok_a_oe,
   input wire logic ok_b_oe,
   output logic supply_on_a,
   output logic supply_on_b,
   output logic power_ok_a,
   output logic power_ok_b
);
   timeunit 1ns;
   timeprecision 1ps;
   assign supply_on_a = en_a;
   assign supply_on_b = en_b;
   // open-drain pins float up to the pull-up when released
   assign power_ok_a = ok_a_oe ? 1'b0 : 1'b1;
   assign power_ok_b = ok_b_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### test/channel_sequencing_light_load_tb_top.sv
`default_nettype none
module channel_sequencing_light_load_tb_top import csll_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en_a = 1'b0;
   logic upd = 1'b0;
   logic sw = 1'b0;
   logic [11:0] cur = 12'h000;
   logic [11:0] tgt = 12'h004;
   csll_bus_t bus = '0;
   csll_fault_t flt = '0;
   logic [7:0] rdata, d, pwm_shed_a;
   logic [2:0] channel_on;
   logic low_load_flag_a, light_coeff_a, ok_a_oe, ok_b_oe, pin_out, pin_oe;
   logic sup_a, sup_b, ok_a, ok_b;
   logic [1:0] pm = 2'h1;
   logic [11:0] ref_a;
   logic [15:0] var1, var2, adj1, adj2;
   int n_mismatch = 0;
   int total_checks = 0;
   initial forever #4 clk = ~clk;
   always @(posedge clk) sw <= ~sw;
   csll_core #(.CYC_PER_MS(10)) u_dut (
      .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .supply_on_a(sup_a), .supply_on_b(sup_b),
      .current_reading_a(cur), .current_reading_b(cur),
      .current_upd_a(upd), .current_upd_b(upd),
      .ref_target_a(tgt), .ref_target_b(tgt),
      .fault_a(flt), .fault_b(flt), .sw_cycle(sw),
      .rise_1(16'h0000), .fall_1(16'h0080), .rise_2(16'h0100),
      .fall_2(16'h0180), .fall_pos_mod(pm),
      .low_load_flag_a(low_load_flag_a), .low_load_flag_b(),
      .pwm_shed_a(pwm_shed_a), .pwm_shed_b(), .light_coeff_a(light_coeff_a),
      .light_coeff_b(), .channel_on(channel_on), .ref_a(ref_a), .ref_b(),
      .odd_output_variation(var1), .even_output_variation(var2),
      .fall_1_adj(adj1), .fall_2_adj(adj2),
      .power_ok_a_in(ok_a), .power_ok_a_out(), .power_ok_a_oe(ok_a_oe),
      .power_ok_b_in(ok_b), .power_ok_b_out(), .power_ok_b_oe(ok_b_oe),
      .flag_sync_out_pin_out(pin_out), .flag_sync_out_pin_oe(pin_oe));
   csll_partner u_far (.en_a(en_a), .en_b(en_a), .ok_a_oe(ok_a_oe),
      .ok_b_oe(ok_b_oe), .supply_on_a(sup_a), .supply_on_b(sup_b),
      .power_ok_a(ok_a), .power_ok_b(ok_b));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // settle just past the edge so registered outputs have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 v = rdata;
   endtask
   task automatic pulse(input logic [11:0] v);
      cur <= v;
      upd <= 1'b1;
      tick(1);
      upd <= 1'b0;
      tick(3);
   endtask
   task automatic wait_on(input int b, input int lim);
      int i;
      for (i = 0; i < lim && channel_on[b] !== 1'b1; i++) tick(1);
      chk({7'h0, channel_on[b]}, 8'h01);
      if (i == lim) complete_run();
   endtask
   initial begin
      tick(5);
      rst_n <= 1'b1;
      tick(1);
      rd(ADDR_FLAG, d);
      chk(d, REG_RESET);
      wr(ADDR_SHED_A, 8'h0f);
      rd(ADDR_SHED_A, d);
      chk(d, 8'h0f);
      rd(16'hfe00, d);
      chk(d, 8'h00);
      $display("registers done");
      wr(ADDR_SEQ_C, 8'h10);
      tick(5);
      chk({7'h0, channel_on[2]}, 8'h00);
      chk(var1, 16'h0080);
      chk(var2, 16'h0080);
      chk(adj1, 16'h0100);
      chk(adj2, 16'h0100);
      wr(ADDR_SEQ_C, 8'h00);
      wr(ADDR_THR_A, 8'h09);
      wr(ADDR_FLAG, 8'h28);
      pulse(12'd575);
      chk({light_coeff_a, low_load_flag_a, pin_oe, pin_out, 4'h0}, 8'he0);
      chk(pwm_shed_a, 8'h0f);
      rd(ADDR_STAT_A, d);
      chk(d & 8'h02, 8'h02);
      pulse(12'd672);
      chk({7'h0, low_load_flag_a}, 8'h01);
      pulse(12'd673);
      chk({light_coeff_a, low_load_flag_a, pin_oe, pin_out, 4'h0}, 8'h30);
      chk(pwm_shed_a, 8'h00);
      pulse(12'd100);
      wr(ADDR_THR_A, 8'h00);
      pulse(12'd0);
      chk({7'h0, low_load_flag_a}, 8'h00);
      $display("light load done");
      chk({6'h0, ok_a_oe, ok_a}, 8'h02);
      wr(ADDR_DBC, 8'h04);
      flt.uv <= 1'b1;
      tick(3);
      chk({6'h0, ok_a_oe, ok_a}, 8'h01);
      flt.uv <= 1'b0;
      tick(1500);
      chk({6'h0, ok_a_oe, ok_a}, 8'h01);
      tick(700);
      chk({6'h0, ok_a_oe, ok_a}, 8'h02);
      $display("power good done");
      chk({7'h0, channel_on[2]}, 8'h01);
      wr(ADDR_SEQ_A, 8'h50);
      wait_on(0, 50);
      wr(ADDR_RST, 8'h05);
      tick(2);
      chk({7'h0, channel_on[0]}, 8'h00);
      tick(4000);
      chk({7'h0, channel_on[0]}, 8'h00);
      wait_on(0, 1500);
      wr(ADDR_SEQ_B, 8'h01);
      en_a <= 1'b1;
      tick(300);
      chk({7'h0, channel_on[1]}, 8'h00);
      wait_on(1, 400);
      chk(ref_a, 16'h0004);
      chk(adj1, 16'h0080);
      $display("sequencing done");
      complete_run();
   end
endmodule
`default_nettype wire
